// >>> shared/dacu_pkg.sv
// Shared constants and types for the converter update and reset control block.
package dacu_pkg;

   localparam int DACU_NCH      = 4;
   localparam int DACU_DW       = 16;
   localparam int DACU_FRAME_W  = 24;

   // Field positions inside a 24-bit frame.
   localparam int DACU_CMD_LSB  = 20;
   localparam int DACU_ADDR_LSB = 16;
   localparam int DACU_MASK_LSB = 0;
   localparam int DACU_REF_BIT  = 0;

   // Reset values and clear codes.
   localparam logic [3:0]         DACU_MASK_RST  = 4'h0;
   localparam logic               DACU_REF_RST   = 1'b0;
   localparam logic [DACU_DW-1:0] DACU_ZERO_CODE = 16'h0000;
   localparam logic [DACU_DW-1:0] DACU_MID_CODE  = 16'h8000;

   // Synchroniser reset levels: idle frame sync and strobe high, hardware reset seen as held.
   localparam logic [3:0] DACU_PIN_SYNC_RST = 4'hC;

   typedef enum logic [3:0] {
      CMD_NOP          = 4'h0,
      CMD_WRITE_INPUT  = 4'h1,
      CMD_UPDATE_DAC   = 4'h2,
      CMD_WRITE_UPDATE = 4'h3,
      CMD_POWER_DOWN   = 4'h4,
      CMD_STROBE_MASK  = 4'h5,
      CMD_SOFT_RESET   = 4'h6,
      CMD_REF_SETUP    = 4'h7
   } dacu_cmd_type;

   typedef struct packed {
      dacu_cmd_type        cmd;
      logic [3:0]          addr;
      logic [DACU_DW-1:0]  data;
   } dacu_frame_type;

   // Order matters: this is the bit layout through the pin synchroniser.
   typedef struct packed {
      logic sync_n;
      logic load_strobe_n;
      logic clear_level_select;
      logic hw_reset_n;
   } dacu_pins_type;

   typedef logic [DACU_NCH-1:0][DACU_DW-1:0] dacu_codes_type;

   typedef enum logic [1:0] {
      ST_WAIT_RELEASE = 2'b00,
      ST_INIT         = 2'b01,
      ST_RUN          = 2'b10,
      ST_HW_RESET     = 2'b11
   } dacu_state_e_type;

   typedef struct packed {
      dacu_state_e_type  st;
      logic              sync_n_d;
      logic              strobe_n_d;
      logic [3:0]        mask;
      logic              ref_off;
      dacu_codes_type    input_q;
      dacu_codes_type    dac_q;
   } dacu_state_type;

endpackage

// >>> hw/dacu_pin_sync.sv
// Two-flop synchroniser for a group of asynchronous pin levels.
`timescale 1ns/1ns
`default_nettype none
module dacu_pin_sync #(
   parameter int               WIDTH   = 4,
   parameter logic [WIDTH-1:0] RST_VAL = '0
) (
   input  wire logic             i_clk,
   input  wire logic             i_rst_n,
   input  wire logic [WIDTH-1:0] i_async,
   output logic      [WIDTH-1:0] o_sync
);

   logic [WIDTH-1:0] meta_reg;

   // The first stage feeds only the second stage.
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         meta_reg <= RST_VAL;
         o_sync   <= RST_VAL;
      end else begin
         meta_reg <= i_async;
         o_sync   <= meta_reg;
      end
   end

endmodule // dacu_pin_sync
`default_nettype wire

// >>> hw/dacu_shifter.sv
// Serial input shift register clocked by the link's own serial clock.
`timescale 1ns/1ns
`default_nettype none
module dacu_shifter #(
   parameter int FRAME_W = 24
) (
   input  wire logic               i_sclk,
   input  wire logic               i_rst_n,
   input  wire logic               i_sync_n,
   input  wire logic               i_serial_data_in,
   output logic      [FRAME_W-1:0] o_frame
);

   // Only the last FRAME_W bits of a frame are kept; the word is left untouched
   // once the frame sync rises, which is what lets the other domain read it.
   always_ff @(posedge i_sclk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_frame <= '0;
      end else if (!i_sync_n) begin
         o_frame <= {o_frame[FRAME_W-2:0], i_serial_data_in};
      end
   end

endmodule // dacu_shifter
`default_nettype wire

// >>> hw/dacu_update_ctrl.sv
// Update, mask, reset and reference control for a four-channel serially loaded converter.
`timescale 1ns/1ns
`default_nettype none
module dacu_update_ctrl
   import dacu_pkg::*;
#(
   parameter int FRAME_W = DACU_FRAME_W
) (
   input  wire logic           i_clk,
   input  wire logic           i_rst_n,
   input  wire logic           i_sclk,
   input  wire logic           i_sync_n,
   input  wire logic           i_serial_data_in,
   input  wire logic           i_load_strobe_n,
   input  wire logic           i_clear_level_select,
   input  wire logic           i_hw_reset_n,
   output dacu_codes_type      o_dac_code,
   output dacu_codes_type      o_input_code,
   output logic [3:0]          o_strobe_mask,
   output logic                o_ref_off,
   output logic                o_ready
);

   ////////////////////////////////////////////////////////////////////////////
   // Link side and crossings
   ////////////////////////////////////////////////////////////////////////////

   logic [FRAME_W-1:0] frame_word;
   dacu_pins_type      pins_raw;
   dacu_pins_type      pins;
   dacu_frame_type     frame;

   // Frames land in the shifter on the serial clock, which stops between frames.
   dacu_shifter #(
      .FRAME_W (FRAME_W)
   ) u_shifter (
      .i_sclk           (i_sclk),
      .i_rst_n          (i_rst_n),
      .i_sync_n         (i_sync_n),
      .i_serial_data_in (i_serial_data_in),
      .o_frame          (frame_word)
   );

   always_comb begin
      pins_raw.sync_n             = i_sync_n;
      pins_raw.load_strobe_n      = i_load_strobe_n;
      pins_raw.clear_level_select = i_clear_level_select;
      pins_raw.hw_reset_n         = i_hw_reset_n;
   end

   dacu_pin_sync #(
      .WIDTH   (4),
      .RST_VAL (DACU_PIN_SYNC_RST)
   ) u_pin_sync (
      .i_clk   (i_clk),
      .i_rst_n (i_rst_n),
      .i_async (pins_raw),
      .o_sync  (pins)
   );

   // The shifter word is only read once the synchronised frame sync has risen,
   // so it has been still for at least two system clocks by then.
   assign frame = dacu_frame_type'(frame_word[DACU_FRAME_W-1:0]);

   ////////////////////////////////////////////////////////////////////////////
   // Helpers
   ////////////////////////////////////////////////////////////////////////////

   function automatic logic [DACU_DW-1:0] clear_code(input logic sel);
      clear_code = sel ? DACU_MID_CODE : DACU_ZERO_CODE;
   endfunction

   function automatic dacu_codes_type all_codes(input logic [DACU_DW-1:0] code);
      dacu_codes_type c;
      c = '0;
      for (int n = 0; n < DACU_NCH; n++) begin
         c[n] = code;
      end
      all_codes = c;
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // State
   ////////////////////////////////////////////////////////////////////////////

   dacu_state_type state_reg;
   dacu_state_type state_next;

   logic frame_done;
   logic strobe_fall;
   logic strobe_low;

   assign frame_done  = pins.sync_n & ~state_reg.sync_n_d;
   assign strobe_fall = ~pins.load_strobe_n & state_reg.strobe_n_d;
   assign strobe_low  = ~pins.load_strobe_n;

   always_comb begin
      state_next            = state_reg;
      state_next.sync_n_d   = pins.sync_n;
      state_next.strobe_n_d = pins.load_strobe_n;

      case (state_reg.st)
         ST_WAIT_RELEASE: begin
            // Initialisation waits for the hardware reset pin to be released.
            // Frames and strobe edges seen here are dropped.
            if (pins.hw_reset_n) begin
               state_next.st = ST_INIT;
            end else begin
               // The held pin already shows the clear code, so a midscale
               // selection is not left at zero while initialisation waits.
               state_next.input_q = all_codes(clear_code(pins.clear_level_select));
               state_next.dac_q   = all_codes(clear_code(pins.clear_level_select));
            end
         end

         ST_INIT: begin
            // Power-up code follows the clear-level select.
            state_next.input_q = all_codes(clear_code(pins.clear_level_select));
            state_next.dac_q   = all_codes(clear_code(pins.clear_level_select));
            state_next.mask    = DACU_MASK_RST;
            state_next.ref_off = DACU_REF_RST;
            state_next.st      = pins.hw_reset_n ? ST_RUN : ST_HW_RESET;
         end

         ST_HW_RESET: begin
            // Outputs forced to the clear code; no update can get through.
            state_next.input_q = all_codes(clear_code(pins.clear_level_select));
            state_next.dac_q   = all_codes(clear_code(pins.clear_level_select));
            if (pins.hw_reset_n) begin
               // Cleared value is simply held from here on.
               state_next.st = ST_RUN;
            end
         end

         ST_RUN: begin
            if (!pins.hw_reset_n) begin
               state_next.st      = ST_HW_RESET;
               state_next.input_q = all_codes(clear_code(pins.clear_level_select));
               state_next.dac_q   = all_codes(clear_code(pins.clear_level_select));
            end else begin
               if (frame_done) begin
                  case (frame.cmd)
                     CMD_WRITE_INPUT: begin
                        for (int n = 0; n < DACU_NCH; n++) begin
                           if (frame.addr[n]) begin
                              state_next.input_q[n] = frame.data;
                              // Strobe held low: the mask is disregarded.
                              if (strobe_low) begin
                                 state_next.dac_q[n] = frame.data;
                              end
                           end
                        end
                     end
                     CMD_UPDATE_DAC: begin
                        for (int n = 0; n < DACU_NCH; n++) begin
                           if (frame.addr[n]) begin
                              state_next.dac_q[n] = state_reg.input_q[n];
                           end
                        end
                     end
                     CMD_WRITE_UPDATE: begin
                        for (int n = 0; n < DACU_NCH; n++) begin
                           if (frame.addr[n]) begin
                              state_next.input_q[n] = frame.data;
                              state_next.dac_q[n]   = frame.data;
                           end
                        end
                     end
                     CMD_STROBE_MASK: begin
                        // Bit n governs channel n; address bits play no part.
                        state_next.mask = frame.data[DACU_MASK_LSB +: DACU_NCH];
                     end
                     CMD_SOFT_RESET: begin
                        state_next.st = ST_INIT;
                     end
                     CMD_REF_SETUP: begin
                        state_next.ref_off = frame.data[DACU_REF_BIT];
                     end
                     default: begin
                        // No-op, power-down and others change nothing; state stays in run.
                        state_next.st = ST_RUN;
                     end
                  endcase
               end

               // A strobe edge after the frame copies the freshest input value.
               if (strobe_fall && (state_next.st == ST_RUN)) begin
                  for (int n = 0; n < DACU_NCH; n++) begin
                     // A masked channel ignores the strobe falling edge.
                     if (!state_reg.mask[n]) begin
                        state_next.dac_q[n] = state_next.input_q[n];
                     end
                  end
               end
            end
         end

         default: begin
            state_next.st = ST_WAIT_RELEASE;
         end
      endcase
   end

   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         state_reg.st         <= ST_WAIT_RELEASE;
         state_reg.sync_n_d   <= 1'b1;
         state_reg.strobe_n_d <= 1'b1;
         state_reg.mask       <= DACU_MASK_RST;
         state_reg.ref_off    <= DACU_REF_RST;
         state_reg.input_q    <= '0;
         state_reg.dac_q      <= '0;
      end else begin
         state_reg <= state_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Outputs
   ////////////////////////////////////////////////////////////////////////////

   assign o_dac_code    = state_reg.dac_q;
   assign o_input_code  = state_reg.input_q;
   assign o_strobe_mask = state_reg.mask;
   assign o_ref_off     = state_reg.ref_off;
   assign o_ready       = (state_reg.st == ST_RUN);

endmodule // dacu_update_ctrl
`default_nettype wire

// >>> dv/dacu_chk.sv
// Port-level assertions for the converter update control block.
`timescale 1ns/1ns
`default_nettype none
module dacu_chk
   import dacu_pkg::*;
(
   input wire logic           i_clk,
   input wire logic           i_rst_n,
   input wire logic           i_sync_n,
   input wire logic           i_load_strobe_n,
   input wire logic           i_clear_level_select,
   input wire logic           i_hw_reset_n,
   input wire dacu_codes_type o_dac_code,
   input wire dacu_codes_type o_input_code,
   input wire logic [3:0]     o_strobe_mask,
   input wire logic           o_ref_off,
   input wire logic           o_ready
);
   logic        seen_reg;
   logic [3:0]  eq;
   logic [63:0] clr4;
   // Pin-level frame seen; it fires earlier than the synchronised copy inside.
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n)
         seen_reg <= 1'b0;
      else
         seen_reg <= seen_reg | ~i_sync_n;
   end
   always_comb begin
      clr4 = {4{i_clear_level_select ? DACU_MID_CODE : DACU_ZERO_CODE}};
      for (int k = 0; k < 4; k++)
         eq[k] = o_dac_code[k] == o_input_code[k];
   end
   ////////////////////////////////////////
   default clocking @(posedge i_clk);
   endclocking
   default disable iff (!i_rst_n);
   sequence hw_held;
      (!i_hw_reset_n && $stable(i_clear_level_select)) [*6];
   endsequence
   sequence strobe_pulse;
      $fell(i_load_strobe_n) ##1 (!i_load_strobe_n) [*4];
   endsequence
   sequence quiet;
      (i_sync_n && o_ready && i_hw_reset_n) [*8];
   endsequence
   ready_drop_a: assert property (
      $fell(i_hw_reset_n) |-> ##[1:4] !o_ready) else $error("ready kept in reset");
   clear_hold_a: assert property (
      hw_held |-> o_dac_code == clr4 && o_input_code == clr4) else $error("bad clear code");
   reset_block_a: assert property (
      hw_held |=> $stable(o_dac_code) && $stable(o_input_code)) else $error("update in reset");
   init_code_a: assert property (
      $rose(o_ready) |-> o_dac_code == clr4 && o_input_code == clr4) else $error("bad init code");
   idle_hold_a: assert property (
      (i_sync_n && i_load_strobe_n && i_hw_reset_n) [*8] |=> $stable(o_dac_code)
      && $stable(o_input_code) && $stable({o_strobe_mask, o_ref_off})) else $error("idle change");
   strobe_copy_a: assert property (
      strobe_pulse |=> &(eq | o_strobe_mask)) else $error("strobe copy missing");
   mask_hold_a: assert property (
      quiet ##0 o_strobe_mask[0] |-> $stable(o_dac_code[0])) else $error("masked change");
   reset_regs_a: assert property (
      !seen_reg |-> o_strobe_mask == DACU_MASK_RST && o_ref_off == DACU_REF_RST)
      else $error("bad reset value");
endmodule // dacu_chk
bind dacu_update_ctrl dacu_chk i_chk (
   .i_clk, .i_rst_n, .i_sync_n, .i_load_strobe_n, .i_clear_level_select, .i_hw_reset_n,
   .o_dac_code, .o_input_code, .o_strobe_mask, .o_ref_off, .o_ready
);
`default_nettype wire

// >>> dv/dacu_host_model.sv
// Host model that drives the serial link one frame at a time.
`timescale 1ns/1ns
`default_nettype none
module dacu_host_model (
   output logic o_sclk,
   output logic o_sync_n,
   output logic o_sdi
);
   initial begin
      o_sclk   = 1'b0;
      o_sync_n = 1'b1;
      o_sdi    = 1'b1;
   end
   // Gated burst of exactly 24 clocks; the clock stands low between frames.
   task automatic send(input logic [23:0] f);
      #7 o_sync_n = 1'b0;
      for (int i = 23; i >= 0; i--) begin
         o_sdi = f[i];
         #62 o_sclk = 1'b1;
         #63 o_sclk = 1'b0;
      end
      #31 o_sync_n = 1'b1;
      o_sdi = ~f[0];
   endtask
endmodule // dacu_host_model
`default_nettype wire

// >>> dv/tb_top.sv
// Self-checking testbench for the update control block.
`timescale 1ns/1ns
`default_nettype none
module tb_top
   import dacu_pkg::*;
;
   logic           clk   = 1'b0;
   logic           rst_n = 1'b0;
   logic           stb_n = 1'b1;
   logic           sel   = 1'b0;
   logic           hw_n  = 1'b1;
   logic           sclk, sync_n, sdi, ref_off, ready;
   logic [3:0]     mask;
   dacu_codes_type dac, inp;
   int             num_errors   = 0;
   int             total_checks = 0;
   always #10 clk = ~clk;
   dacu_host_model i_host (.o_sclk(sclk), .o_sync_n(sync_n), .o_sdi(sdi));
   dacu_update_ctrl i_dut (
      .i_clk(clk), .i_rst_n(rst_n), .i_sclk(sclk), .i_sync_n(sync_n),
      .i_serial_data_in(sdi), .i_load_strobe_n(stb_n), .i_clear_level_select(sel),
      .i_hw_reset_n(hw_n), .o_dac_code(dac), .o_input_code(inp),
      .o_strobe_mask(mask), .o_ref_off(ref_off), .o_ready(ready)
   );
   ////////////////////////////////////////
   task automatic chk(input logic [63:0] got, input logic [63:0] exp);
      total_checks++;
      if (got !== exp) begin
         num_errors++;
         $display("CHECK FAILED %0t got %h want %h", $time, got, exp);
      end
   endtask
   task automatic give_verdict();
      if (num_errors == 0 && total_checks > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   task automatic cyc(input int n);
      repeat (n) @(negedge clk);
   endtask
   task automatic frm(input logic [3:0] c, input logic [3:0] a, input logic [15:0] d);
      i_host.send({c, a, d});
      cyc(8);
   endtask
   task automatic pulse();
      stb_n = 1'b0;
      cyc(6);
      stb_n = 1'b1;
      cyc(6);
   endtask
   task automatic wait_ready();
      int n;
      n = 0;
      while (ready !== 1'b1 && n < 50) begin
         cyc(1);
         n++;
      end
      chk(ready, 1'b1);
   endtask
   ////////////////////////////////////////
   task automatic t_defer();
      frm(CMD_WRITE_INPUT, 4'h5, 16'h1234);
      chk(inp, {16'h0, 16'h1234, 16'h0, 16'h1234});
      chk(dac, '0);
      pulse();
      chk(dac, {16'h0, 16'h1234, 16'h0, 16'h1234});
   endtask
   task automatic t_cmds();
      frm(CMD_WRITE_INPUT, 4'h8, 16'h0F0F);
      frm(CMD_UPDATE_DAC, 4'h8, 16'hFFFF);
      chk({inp[3], dac[3]}, {2{16'h0F0F}});
      frm(CMD_WRITE_UPDATE, 4'h2, 16'h7777);
      chk({inp[1], dac[1]}, {2{16'h7777}});
   endtask
   task automatic t_mask();
      frm(CMD_STROBE_MASK, 4'hF, 16'hFFF5);
      chk(mask, 4'h5);
      frm(CMD_WRITE_INPUT, 4'hF, 16'hAAAA);
      pulse();
      chk(dac, {16'hAAAA, 16'h1234, 16'hAAAA, 16'h1234});
      stb_n = 1'b0;
      cyc(6);
      frm(CMD_WRITE_INPUT, 4'h5, 16'h5A5A);
      chk(dac, {16'hAAAA, 16'h5A5A, 16'hAAAA, 16'h5A5A});
      stb_n = 1'b1;
      cyc(6);
   endtask
   task automatic t_ref();
      frm(CMD_REF_SETUP, 4'hF, 16'hFFFE);
      chk(ref_off, 1'b0);
      frm(CMD_REF_SETUP, 4'h0, 16'h0001);
      chk(ref_off, 1'b1);
      frm(CMD_NOP, 4'hF, 16'h1357);
      frm(CMD_POWER_DOWN, 4'hF, 16'h00FF);
      chk(inp, {2{16'hAAAA, 16'h5A5A}});
      chk(dac, {2{16'hAAAA, 16'h5A5A}});
   endtask
   task automatic t_hw();
      sel = 1'b1;
      frm(CMD_WRITE_UPDATE, 4'hF, 16'h1111);
      hw_n = 1'b0;
      cyc(6);
      frm(CMD_WRITE_UPDATE, 4'hF, 16'h2222);
      chk(ready, 1'b0);
      chk(dac, {4{16'h8000}});
      hw_n = 1'b1;
      wait_ready();
      cyc(8);
      chk(dac, {4{16'h8000}});
   endtask
   task automatic t_soft();
      frm(CMD_WRITE_UPDATE, 4'hF, 16'h3333);
      frm(CMD_SOFT_RESET, 4'h0, 16'h0);
      wait_ready();
      chk(inp, {4{16'h8000}});
      chk({mask, ref_off}, 5'h0);
   endtask
   task automatic t_boot();
      sel = 1'b0;
      hw_n = 1'b0;
      rst_n = 1'b0;
      cyc(2);
      stb_n = 1'b0;
      cyc(4);
      stb_n = 1'b1;
      cyc(2);
      rst_n = 1'b1;
      cyc(20);
      chk(ready, 1'b0);
      hw_n = 1'b1;
      wait_ready();
      chk(dac, '0);
   endtask
   ////////////////////////////////////////
   initial begin
      cyc(16);
      rst_n = 1'b1;
      wait_ready();
      t_defer();
      t_cmds();
      t_mask();
      t_ref();
      t_hw();
      t_soft();
      t_boot();
      give_verdict();
   end
   // About fifteen frames of some 3 us each; this span leaves wide margin.
   initial begin
      #250000;
      num_errors++;
      give_verdict();
   end
endmodule // tb_top
`default_nettype wire
